// [pbr_reset_seq.sv]
// power-on, power-up timer and brown-out reset sequencer with apb status and control
`timescale 1ns/100ps
module pbr_reset_seq
  import pbr_pkg::*;
#(
  parameter int unsigned POWER_UP_TIMER_CYC   = POWER_UP_TIMER_CYCLES,
  parameter int unsigned FILTER_CYC = BOR_FILTER_CYC
) (
  // apb clock, reset and bus
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // configuration word fields
  input  wire logic [1:0]  brownout_mode_sel,
  input  wire logic        power_up_delay_enable_n,
  input  wire logic        brownout_level_cfg,
  input  wire logic        external_reset_pin_enable,
  // analog detectors
  input  wire logic        por_level_ok,
  input  wire logic        supply_below_threshold,
  input  wire logic        brownout_detector_ready,
  // other reset sources and start-up conditions
  input  wire logic        external_reset_pin_n,
  input  wire logic        watchdog_reset,
  input  wire logic        reset_instruction,
  input  wire logic        stack_overflow,
  input  wire logic        stack_underflow,
  input  wire logic        programming_exit,
  input  wire logic        osc_startup_done,
  input  wire logic        device_sleep,
  // outputs
  output logic             device_reset,
  output logic             brownout_detector_enable,
  output logic             brownout_level_sel,
  output logic             wake_allow
);

  pbr_top_s      q_r;
  pbr_top_s      q_nxt;
  pbr_apb_req_s  req;
  pbr_bor_mode_e mode;
  logic          bor_on;
  logic          protect;
  logic          bor_trip;
  logic          power_fail;
  logic          warm_reset;
  logic          bor_wait_ok;
  logic          pin_released;
  logic          power_up_timer_done;
  logic          power_up_timer_restart;
  logic          power_up_timer_run;
  logic          addr_ctrl;
  logic          addr_stat;
  logic [31:0]   rd_word;

  assign req  = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata, pstrb: pstrb};
  assign mode = pbr_bor_mode_e'(brownout_mode_sel);

  // detector enable per mode; the software bit only counts in software mode
  always_comb begin
    case (mode)
      BOR_ON:        bor_on = 1'b1;
      BOR_SLEEP_OFF: bor_on = !device_sleep;
      BOR_SW:        bor_on = q_r.sw_en;
      default:       bor_on = 1'b0;
    endcase
  end

  // protection needs a ready detector, otherwise its output is meaningless
  assign protect = bor_on && brownout_detector_ready;

  pbr_filter #(
    .FILTER_CYC (FILTER_CYC)
  ) u_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .protect (protect),
    .below   (supply_below_threshold),
    .trip    (bor_trip)
  );

  // programming exit behaves as a fresh power-on
  assign power_fail = !por_level_ok || bor_trip || programming_exit;
  assign warm_reset = watchdog_reset || reset_instruction || stack_overflow || stack_underflow;

  // only the always-on and off-in-sleep modes wait on the detector at start-up
  assign bor_wait_ok = !((mode == BOR_ON) || (mode == BOR_SLEEP_OFF)) ||
                       (brownout_detector_ready && !supply_below_threshold);

  assign pin_released = !external_reset_pin_enable || external_reset_pin_n;

  assign power_up_timer_restart = (q_r.st == ST_HOLD) || (q_r.st == ST_BORWAIT);
  assign power_up_timer_run     = (q_r.st == ST_POWER_UP_TIMER);

  pbr_timer #(
    .CYCLES (POWER_UP_TIMER_CYC)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (power_up_timer_restart),
    .run     (power_up_timer_run),
    .done    (power_up_timer_done)
  );

  // apb decode
  assign addr_ctrl = (req.paddr == OFS_BROWNOUT_CTRL);
  assign addr_stat = (req.paddr == OFS_SEQ_STATUS);

  always_comb begin
    rd_word = '0;
    if (addr_ctrl) begin
      rd_word[BIT_SW_BOR_EN] = q_r.sw_en;
      rd_word[BIT_BOR_READY] = brownout_detector_ready;
    end else if (addr_stat) begin
      rd_word[BIT_ST_DEV_RST]              = q_r.dev_rst;
      rd_word[BIT_ST_POWER_UP_TIMER_RUN]             = power_up_timer_run;
      rd_word[BIT_ST_PROTECT]              = protect;
      rd_word[BIT_ST_LEVEL]                = brownout_level_cfg;
      rd_word[BIT_ST_WAKE_OK]              = q_r.wake_ok;
      rd_word[BIT_ST_STATE +: 3]           = q_r.st;
    end
  end

  always_comb begin
    q_nxt = q_r;

    // read data and error are latched in the setup cycle so the access phase needs no wait
    if (req.psel && !req.penable) begin
      q_nxt.prdata = req.pwrite ? 32'h0000_0000 : rd_word;
      q_nxt.slverr = !(addr_ctrl || addr_stat);
    end
    if (req.psel && req.penable && req.pwrite && addr_ctrl && req.pstrb[0]) begin
      q_nxt.sw_en = req.pwdata[BIT_SW_BOR_EN];
    end

    case (q_r.st)
      ST_HOLD: begin
        if (!power_fail) begin
          if (!bor_wait_ok) begin
            q_nxt.st = ST_BORWAIT;
          end else if (!power_up_delay_enable_n) begin
            q_nxt.st = ST_POWER_UP_TIMER;
          end else begin
            q_nxt.st = ST_START;
          end
        end
      end
      ST_BORWAIT: begin
        if (bor_wait_ok) begin
          q_nxt.st = power_up_delay_enable_n ? ST_START : ST_POWER_UP_TIMER;
        end
      end
      ST_POWER_UP_TIMER: begin
        // the timer ignores the reset pin; a held pin is then waited for in start before run
        if (power_up_timer_done) begin
          q_nxt.st = ST_START;
        end
      end
      ST_START: begin
        if (osc_startup_done && pin_released) begin
          q_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!pin_released) begin
          q_nxt.st = ST_START;
        end
      end
      default: begin
        q_nxt.st = ST_HOLD;
      end
    endcase

    if (warm_reset && (q_r.st == ST_RUN)) begin
      q_nxt.st = ST_START;
    end
    if (power_fail) begin
      q_nxt.st = ST_HOLD;
    end

    q_nxt.dev_rst = (q_nxt.st != ST_RUN) || warm_reset;
    // only the off-in-sleep mode has to wait for the detector to come back
    q_nxt.wake_ok = !((mode == BOR_SLEEP_OFF) && !brownout_detector_ready);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r       <= '0;
      q_r.st    <= ST_HOLD;
      q_r.dev_rst <= 1'b1;
      q_r.sw_en <= RST_SW_BOR_EN;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign pready                   = 1'b1;
  assign prdata                   = q_r.prdata;
  assign pslverr                  = req.psel && req.penable && q_r.slverr;
  assign device_reset             = q_r.dev_rst;
  assign brownout_detector_enable = bor_on;
  assign brownout_level_sel       = brownout_level_cfg;
  assign wake_allow               = q_r.wake_ok;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  por_hold_a: assert property (!por_level_ok |=> device_reset && q_r.st == ST_HOLD) else $error("reset not held on low power");
  power_up_timer_hold_a: assert property (q_r.st == ST_POWER_UP_TIMER |-> device_reset) else $error("reset released during power-up delay");
  power_up_timer_start_a: assert property (q_r.st == ST_POWER_UP_TIMER && $past(q_r.st) != ST_POWER_UP_TIMER |-> $past(!power_fail)) else $error("timer started under fail");
  power_up_timer_enable_a: assert property (q_r.st == ST_POWER_UP_TIMER |-> !$past(power_up_delay_enable_n)) else $error("timer ran while disabled");
  bor_wait_a: assert property (q_r.st == ST_BORWAIT && !bor_wait_ok && !power_fail |=> q_r.st == ST_BORWAIT) else $error("start-up did not wait for detector");
  on_mode_a: assert property (mode == BOR_ON |-> brownout_detector_enable) else $error("always-on detector switched off");
  sleep_off_a: assert property (mode == BOR_SLEEP_OFF |-> brownout_detector_enable == !device_sleep) else $error("off-in-sleep enable wrong");
  wake_hold_a: assert property (mode == BOR_SLEEP_OFF && !brownout_detector_ready |=> !wake_allow) else $error("wake not held back");
  sw_mode_a: assert property (mode == BOR_SW |-> brownout_detector_enable == q_r.sw_en) else $error("software enable ignored");
  sw_nowait_a: assert property (mode == BOR_SW && q_r.st == ST_HOLD && !power_fail |=> q_r.st != ST_BORWAIT) else $error("software mode waited");
  off_mode_a: assert property (mode == BOR_OFF |-> !brownout_detector_enable && q_r.st != ST_BORWAIT) else $error("off mode active");
  no_delay_a: assert property (q_r.st == ST_HOLD && !power_fail && bor_wait_ok && power_up_delay_enable_n |=> q_r.st == ST_START || q_r.st == ST_HOLD) else $error("extra start delay");
  release_a: assert property (!device_reset && $past(device_reset) |-> $past(osc_startup_done) && $past(pin_released)) else $error("released before start-up done");

  // sources, start-up order, sleep gating and register side effects
  warm_src_a: assert property (warm_reset |=> device_reset)
    else $error("warm reset not applied");
  pin_src_a: assert property (q_r.st == ST_RUN && !pin_released |=> device_reset)
    else $error("pin reset not applied");
  prog_src_a: assert property (programming_exit |=> q_r.st == ST_HOLD)
    else $error("programming exit not a power-on");
  idle_reset_a: assert property (q_r.st != ST_RUN |-> device_reset)
    else $error("reset released outside run");
  power_up_timer_keep_a: assert property (q_r.st == ST_POWER_UP_TIMER && !power_up_timer_done && !power_fail |=> q_r.st == ST_POWER_UP_TIMER)
    else $error("power-up delay cut short");
  power_up_timer_clear_a: assert property (power_up_timer_restart |=> !power_up_timer_done)
    else $error("timer not cleared while waiting");
  power_up_timer_entry_a: assert property (q_r.st == ST_POWER_UP_TIMER |-> $past(q_r.st) != ST_START && $past(q_r.st) != ST_RUN)
    else $error("timer entered from wrong state");
  power_up_timer_taken_a: assert property (q_r.st == ST_HOLD && !power_fail && bor_wait_ok && !power_up_delay_enable_n |=> q_r.st == ST_POWER_UP_TIMER)
    else $error("enabled timer skipped");
  osc_wait_a: assert property (q_r.st == ST_START && !osc_startup_done |=> device_reset)
    else $error("released before oscillator ready");
  pin_wait_a: assert property (q_r.st == ST_START && !pin_released |=> device_reset)
    else $error("released while pin held");
  run_keep_a: assert property (q_r.st == ST_RUN && pin_released && !warm_reset && !power_fail |=> !device_reset)
    else $error("reset in run without cause");
  trip_rst_a: assert property (bor_trip |=> device_reset && q_r.st == ST_HOLD)
    else $error("filter trip ignored");
  trip_off_a: assert property (!protect |=> !bor_trip)
    else $error("trip without protection");
  borwait_ok_a: assert property (q_r.st == ST_BORWAIT && bor_wait_ok && !power_fail |=> q_r.st != ST_BORWAIT)
    else $error("satisfied wait delayed");
  sw_sleep_a: assert property (mode == BOR_SW && $stable(q_r.sw_en) && $stable(brownout_mode_sel) |-> $stable(brownout_detector_enable))
    else $error("sleep changed software protection");
  wake_on_a: assert property (mode == BOR_ON |=> wake_allow)
    else $error("always-on mode held wake");
  wake_sw_a: assert property (mode == BOR_SW |=> wake_allow)
    else $error("software mode held wake");
  wake_off_a: assert property (mode == BOR_OFF |=> wake_allow)
    else $error("off mode held wake");
  wake_back_a: assert property (mode == BOR_SLEEP_OFF && brownout_detector_ready |=> wake_allow)
    else $error("wake held with ready detector");
  sw_write_a: assert property (psel && penable && pwrite && addr_ctrl && pstrb[0] |=> q_r.sw_en == $past(pwdata[BIT_SW_BOR_EN]))
    else $error("software enable write lost");
  sw_keep_a: assert property (!(psel && penable && pwrite && addr_ctrl) |=> $stable(q_r.sw_en))
    else $error("software enable changed without write");
  rdy_read_a: assert property (psel && !penable && !pwrite && addr_ctrl |=> prdata[BIT_BOR_READY] == $past(brownout_detector_ready))
    else $error("ready bit read wrong");
  sw_read_a: assert property (psel && !penable && !pwrite && addr_ctrl |=> prdata[BIT_SW_BOR_EN] == $past(q_r.sw_en))
    else $error("software enable read wrong");
  unmapped_a: assert property (psel && penable && !addr_ctrl && !addr_stat |-> pslverr)
    else $error("unmapped access without error");
  level_pass_a: assert property (brownout_level_sel == brownout_level_cfg)
    else $error("trip level not passed on");
endmodule

// [pbr_pkg.sv]
// shared constants, types and state records for the power-on and brown-out reset sequencer
package pbr_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned POWER_UP_TIMER_TIME_MS    = 64;
  localparam int unsigned POWER_UP_TIMER_CYCLES     = POWER_UP_TIMER_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned BOR_FILTER_NS   = 1000;
  localparam int unsigned BOR_FILTER_CALC = (BOR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BOR_FILTER_CYC  = (BOR_FILTER_CALC < 1) ? 1 : BOR_FILTER_CALC;

  // register byte offsets
  localparam logic [11:0] OFS_BROWNOUT_CTRL = 12'h000;
  localparam logic [11:0] OFS_SEQ_STATUS    = 12'h004;

  // brownout_control_reg fields
  localparam int unsigned BIT_SW_BOR_EN    = 7;
  localparam int unsigned BIT_BOR_READY    = 0;
  localparam logic        RST_SW_BOR_EN    = 1'b1;

  // sequencer status fields
  localparam int unsigned BIT_ST_DEV_RST   = 0;
  localparam int unsigned BIT_ST_POWER_UP_TIMER_RUN  = 1;
  localparam int unsigned BIT_ST_PROTECT   = 2;
  localparam int unsigned BIT_ST_LEVEL     = 3;
  localparam int unsigned BIT_ST_WAKE_OK   = 4;
  localparam int unsigned BIT_ST_STATE     = 8;

  typedef enum logic [1:0] {
    BOR_OFF       = 2'b00,
    BOR_SW        = 2'b01,
    BOR_SLEEP_OFF = 2'b10,
    BOR_ON        = 2'b11
  } pbr_bor_mode_e;

  // gray along hold -> bor wait -> power-up timer -> start -> run
  typedef enum logic [2:0] {
    ST_HOLD    = 3'b000,
    ST_BORWAIT = 3'b001,
    ST_POWER_UP_TIMER    = 3'b011,
    ST_START   = 3'b010,
    ST_RUN     = 3'b110
  } pbr_state_e;

  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } pbr_apb_req_s;

  typedef struct packed {
    pbr_state_e  st;
    logic        dev_rst;
    logic        sw_en;
    logic        wake_ok;
    logic        slverr;
    logic [31:0] prdata;
  } pbr_top_s;

endpackage

// [pbr_filter.sv]
// brown-out glitch filter: trips only after the supply stays low longer than the filter time
`timescale 1ns/100ps
module pbr_filter
  import pbr_pkg::*;
#(
  parameter int unsigned FILTER_CYC = BOR_FILTER_CYC
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // detector side
  input  wire logic protect,
  input  wire logic below,
  // trip
  output logic      trip
);
  localparam int unsigned W = $clog2(FILTER_CYC + 2);
  localparam logic [W-1:0] LIMIT = W'(FILTER_CYC);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         trip;
  } pbr_flt_s;

  pbr_flt_s q_r;
  pbr_flt_s q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (!protect || !below) begin
      q_nxt.cnt  = '0;
      q_nxt.trip = 1'b0;
    end else if (q_r.cnt < LIMIT) begin
      q_nxt.cnt = q_r.cnt + W'(1);
    end else begin
      // low for more than the filter time
      q_nxt.trip = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign trip = q_r.trip;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  trip_cause_a: assert property (trip |-> q_r.cnt == LIMIT) else $error("filter trip before limit");
  dip_reject_a: assert property (!below |=> !trip) else $error("filter trip without low supply");
endmodule

// [pbr_timer.sv]
// power-up delay counter, cleared while power is failing and counting while allowed
`timescale 1ns/100ps
module pbr_timer
  import pbr_pkg::*;
#(
  parameter int unsigned CYCLES = POWER_UP_TIMER_CYCLES
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic restart,
  input  wire logic run,
  // status
  output logic      done
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } pbr_tmr_s;

  pbr_tmr_s q_r;
  pbr_tmr_s q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (restart) begin
      q_nxt = '0;
    end else if (run && !q_r.done) begin
      if (q_r.cnt == LAST) begin
        q_nxt.done = 1'b1;
      end else begin
        q_nxt.cnt = q_r.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign done = q_r.done;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  done_cause_a: assert property ($rose(done) |-> $past(run) && $past(q_r.cnt) == LAST) else $error("timer done early");
endmodule

// [pbr_reset_seq_test.sv]
// self-checking bench for the power-on and brown-out reset sequencer
`timescale 1ns/100ps
module pbr_reset_seq_test;
  import pbr_pkg::*;
  // short counts keep the run brief; expectations derive from these
  localparam int PW = 20;
  localparam int FC = 3;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [3:0]  pstrb, warm;
  logic [1:0]  mode;
  logic        pwr_n, lvl, pin_en, por_ok, below, ready, pin_n, prog, osc, sleep;
  logic        device_reset, det_en, lvl_out, wake, err;
  logic [4:0]  cases [7];
  int          errors, n_compared, cycles, n;

  pbr_reset_seq #(.POWER_UP_TIMER_CYC(PW), .FILTER_CYC(FC)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .brownout_mode_sel(mode), .power_up_delay_enable_n(pwr_n),
    .brownout_level_cfg(lvl), .external_reset_pin_enable(pin_en), .por_level_ok(por_ok),
    .supply_below_threshold(below), .brownout_detector_ready(ready),
    .external_reset_pin_n(pin_n), .watchdog_reset(warm[0]), .reset_instruction(warm[1]),
    .stack_overflow(warm[2]), .stack_underflow(warm[3]), .programming_exit(prog),
    .osc_startup_done(osc), .device_sleep(sleep), .device_reset(device_reset),
    .brownout_detector_enable(det_en), .brownout_level_sel(lvl_out), .wake_allow(wake));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // called just after a rising edge; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so a following call never re-drives psel in this time step
    @(posedge pclk);
  endtask

  task automatic por_cycle(input logic [1:0] m, input logic pn);
    por_ok <= 1'b0;
    repeat (2) @(posedge pclk);
    mode <= m;
    pwr_n <= pn;
    por_ok <= 1'b1;
  endtask

  task automatic wait_rel(input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (device_reset !== 1'b0 && n < lim);
  endtask

  task automatic test_end(input string name);
    $display("test %s done, %0d mismatches so far", name, errors);
  endtask

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, warm, mode, lvl, por_ok, below, ready} = '0;
    {prog, sleep, presetn, errors, n_compared, cycles} = '0;
    {pstrb, pwr_n, pin_en, pin_n, osc} = {4'hf, 4'hf};
    // mode, software enable, sleep, expected brown-out reset
    cases = '{5'h1d, 5'h1f, 5'h15, 5'h16, 5'h0f, 5'h08, 5'h04};
    void'($urandom(84));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_BROWNOUT_CTRL, 32'h0000_0000);
    chk_word("ctrl after reset", 32'h0000_0080, rd);
    repeat (30) @(posedge pclk);
    chk_bit("reset while supply low", 1'b1, device_reset);
    test_end("power on hold");
    ready <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      por_cycle(m[1:0], 1'b1);
      wait_rel(40);
      chk_word("start-up edges", 32'd3, n);
    end
    ready <= 1'b0;
    por_cycle(2'h1, 1'b1);
    wait_rel(40);
    chk_word("sw mode start-up edges", 32'd3, n);
    por_cycle(2'h3, 1'b1);
    wait_rel(40);
    chk_bit("held until ready", 1'b1, device_reset);
    ready <= 1'b1;
    wait_rel(40);
    chk_bit("release after ready", 1'b1, n <= 4);
    below <= 1'b1;
    por_cycle(2'h2, 1'b1);
    wait_rel(40);
    chk_bit("held while below", 1'b1, device_reset);
    below <= 1'b0;
    wait_rel(40);
    chk_bit("release when above", 1'b1, n <= 4);
    test_end("start-up gating");
    por_cycle(2'h0, 1'b0);
    @(posedge pclk);
    apb(1'b0, OFS_SEQ_STATUS, 32'h0000_0000);
    chk_word("status in timer", 32'h0000_0303, rd & 32'h0000_0703);
    wait_rel(PW + 20);
    chk_bit("timer length", 1'b1, n + 2 > PW && n + 2 <= PW + 6);
    test_end("power-up timer");
    por_cycle(2'h3, 1'b1);
    wait_rel(40);
    below <= 1'b1;
    repeat (FC) @(posedge pclk);
    below <= 1'b0;
    repeat (4) @(posedge pclk);
    chk_bit("short dip ignored", 1'b0, device_reset);
    for (int i = 0; i < 7; i++) begin
      mode <= cases[i][4:3];
      sleep <= cases[i][1];
      apb(1'b1, OFS_BROWNOUT_CTRL, {24'h00_0000, cases[i][2], 7'h00});
      below <= 1'b1;
      repeat (FC + 3) @(posedge pclk);
      chk_bit("brown-out trip", cases[i][0], device_reset);
      below <= 1'b0;
      sleep <= 1'b0;
      wait_rel(40);
      chk_bit("back to run", 1'b0, device_reset);
    end
    test_end("brown-out modes");
    for (int i = 0; i < 16; i++) begin
      mode <= i[3:2];
      sleep <= i[1];
      ready <= i[0];
      d = $urandom;
      lvl <= d[0];
      apb(1'b1, OFS_BROWNOUT_CTRL, d);
      apb(1'b0, OFS_BROWNOUT_CTRL, 32'h0000_0000);
      chk_word("ctrl readback", {24'h00_0000, d[7], 6'h00, i[0]}, rd);
      chk_bit("detector enable", i[3:2] == 3 || (i[3:2] == 2 && !i[1]) || (i[3:2] == 1 && d[7]), det_en);
      chk_bit("wake allow", !(i[3:2] == 2 && !i[0]), wake);
      chk_bit("level select", d[0], lvl_out);
    end
    {sleep, ready} <= 2'h1;
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk_bit("unmapped error", 1'b1, err);
    chk_word("unmapped data", 32'h0000_0000, rd);
    apb(1'b0, OFS_SEQ_STATUS, 32'h0000_0000);
    chk_word("status in run", 32'h0000_0600, rd & 32'h0000_0701);
    test_end("registers");
    for (int k = 0; k < 6; k++) begin
      warm <= 4'(4'h1 << k);
      pin_n <= (k != 4);
      prog <= (k == 5);
      @(posedge pclk);
      {warm, prog, pin_n} <= 6'h01;
      @(posedge pclk);
      chk_bit("source resets", 1'b1, device_reset);
      wait_rel(40);
      chk_bit("source released", 1'b0, device_reset);
    end
    pin_en <= 1'b0;
    pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk_bit("disabled pin ignored", 1'b0, device_reset);
    {pin_en, osc} <= 2'h2;
    por_cycle(2'h0, 1'b1);
    wait_rel(30);
    chk_bit("held by pin and oscillator", 1'b1, device_reset);
    osc <= 1'b1;
    wait_rel(10);
    chk_bit("held by pin", 1'b1, device_reset);
    pin_n <= 1'b1;
    wait_rel(10);
    chk_bit("starts on pin release", 1'b1, n <= 3);
    test_end("reset sources");
    finish_test();
  end
endmodule
